//--- rtl/ttm_pkg.sv
// Shared constants for the thermal trip monitor.
// Assumes a host register port that selects registers by a 3-bit pointer.
package ttm_pkg;

  // ==========================================================
  // Register pointer values
  localparam logic [2:0] ADDR_CAPABILITY = 3'h0;
  localparam logic [2:0] ADDR_CONFIG = 3'h1;
  localparam logic [2:0] ADDR_UPPER = 3'h2;
  localparam logic [2:0] ADDR_LOWER = 3'h3;
  localparam logic [2:0] ADDR_CRITICAL = 3'h4;
  localparam logic [2:0] ADDR_TEMP = 3'h5;

  // ==========================================================
  // Configuration bit positions
  localparam int CFG_EVT_MODE = 0;
  localparam int CFG_EVT_POL = 1;
  localparam int CFG_CRIT_ONLY = 2;
  localparam int CFG_EVT_EN = 3;
  localparam int CFG_EVT_STAT = 4;
  localparam int CFG_CLR_EVT = 5;
  localparam int CFG_ALARM_LOCK = 6;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_SHUTDOWN = 8;
  localparam int CFG_HYST_LO = 9;
  localparam int CFG_HYST_HI = 10;

  // Bits software may store; status, clear and reserved excluded
  localparam logic [15:0] CFG_STORE_MASK = 16'h07CF;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // ==========================================================
  // Trip and temperature field layout
  localparam int TRIP_MSB = 12;
  localparam int TRIP_LSB = 2;
  localparam logic [15:0] TRIP_MASK = 16'h1FFC;
  localparam logic [15:0] TRIP_RESET = 16'h0000;
  localparam int TEMP_MSB = 12;
  localparam int TEMP_BELOW = 13;
  localparam int TEMP_ABOVE = 14;
  localparam int TEMP_CRIT = 15;
  localparam logic [12:0] TEMP_RESET = 13'h0000;

  // ==========================================================
  // Hysteresis in 0.25 degree steps: 0, 1.5, 3, 6 degrees
  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] HYST_1P5 = 2'h1;
  localparam logic [1:0] HYST_3 = 2'h2;
  localparam logic [1:0] HYST_6 = 2'h3;
  localparam logic [11:0] HYST_Q_OFF = 12'h000;
  localparam logic [11:0] HYST_Q_1P5 = 12'h006;
  localparam logic [11:0] HYST_Q_3 = 12'h00C;
  localparam logic [11:0] HYST_Q_6 = 12'h018;

  // ==========================================================
  // Trip comparator indices
  localparam int TRIP_UPPER = 0;
  localparam int TRIP_LOWER = 1;
  localparam int TRIP_CRIT = 2;
  localparam int TRIP_COUNT = 3;

endpackage

//--- rtl/ttm_trip.sv
// One trip-point comparator with hysteresis and a held flag.
// Assumes temperature and trip value share 0.25 degree alignment.
`timescale 1ns/1ps
module ttm_trip (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Comparison inputs
  input wire logic above_sense,
  input wire logic [10:0] temp_q,
  input wire logic [10:0] trip_q,
  input wire logic [11:0] hyst_q,
  // Flag
  output logic flag
);

  typedef struct packed {
    logic flag;
  } ttm_trip_state_type;

  ttm_trip_state_type st_r;
  ttm_trip_state_type st_nxt;
  logic signed [11:0] temp_s;
  logic signed [11:0] trip_s;
  logic signed [11:0] band_s;

  // ==========================================================
  // Compare with hysteresis
  always_comb begin
    st_nxt = st_r;
    temp_s = $signed({temp_q[10], temp_q});
    trip_s = $signed({trip_q[10], trip_q});
    band_s = trip_s - $signed(hyst_q);
    if (above_sense) begin
      if (temp_s > trip_s) begin
        st_nxt.flag = 1'b1;
      end else if (temp_s <= band_s) begin
        st_nxt.flag = 1'b0;
      end
    end else begin
      if (temp_s < band_s) begin
        st_nxt.flag = 1'b1;
      end else if (temp_s >= trip_s) begin
        st_nxt.flag = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

  // ==========================================================
  // Checks
  sequence above_over_s;
    ce && above_sense && (temp_s > trip_s);
  endsequence

  sequence above_held_s;
    ce && above_sense && st_r.flag && (temp_s > band_s);
  endsequence

  above_set_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    above_over_s |=> st_r.flag)
    else $error("above flag not set past trip");

  hyst_hold_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    above_held_s |=> st_r.flag)
    else $error("above flag dropped inside hysteresis band");

  below_clear_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    ce && !above_sense && (temp_s >= trip_s) |=> !st_r.flag)
    else $error("below flag not cleared at lower bound");

endmodule

//--- rtl/ttm_monitor.sv
// Thermal trip monitor: trip registers, temperature readout, event pin.
// Assumes a host register port and a sensor sample port on core_clk.
//
// How it works
// - Alarm lock bit 6 set blocks writes to upper and lower bounds.
// - Critical lock bit 7 set blocks writes to the critical limit.
// - Config bit 8 set shuts the sensor down and freezes sensing.
// - Config bits 10:9 pick hysteresis of 0, 1.5, 3 or 6 degrees.
// - Hysteresis acts on both window flags and on the event pin.
// - Below sets under lower-hyst, clears at lower; above sets over upper, clears at upper-hyst.
// - A tripped above or critical flag holds until temperature falls to trip minus hyst.
// - Trip values and temperature are two's complement numbers.
// - Bound registers hold their value in bits 12:2, 0.25 degree step.
// - Bound register bits 15:13 and 1:0 always read zero.
// - Critical limit uses 0.25 degree steps, bits 15:13, 1:0 read zero.
// - Temperature is read-only, bits 12:0 at 0.0625 degree per step.
// - Temperature bit 13 reads the below-window flag.
// - Temperature bit 14 reads the above-window flag.
// - Temperature bit 15 reads the above-critical flag.
// - Either lock bit set freezes the event mode and polarity bits.
`timescale 1ns/1ps
module ttm_monitor #(
  parameter logic [15:0] CAPABILITY = 16'h0001
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Host register port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // Sensor sample port
  input wire logic sensor_valid,
  input wire logic [12:0] sensor_temp,
  output logic sensor_shutdown,
  // Event pin
  output logic event_pin
);

  // ==========================================================
  // Parameter check
  if (CAPABILITY[15:5] != 11'h000) begin : g_bad_cap
    $error("capability upper bits must be zero");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] crit;
    logic [12:0] temp;
    logic [15:0] rdata;
    logic rvalid;
    logic cond_prev;
    logic evt_latch;
    logic evt_pin;
  } ttm_state_type;

  ttm_state_type st_r;
  ttm_state_type st_nxt;

  logic [11:0] hyst_q;
  logic [10:0] trip_sel [ttm_pkg::TRIP_COUNT];
  logic [ttm_pkg::TRIP_COUNT-1:0] flags;
  logic evt_cond;
  logic evt_active;
  logic locked_any;
  logic [15:0] cfg_read;
  logic [15:0] temp_read;

  // ==========================================================
  // Hysteresis decode
  always_comb begin
    unique case (st_r.cfg[ttm_pkg::CFG_HYST_HI:ttm_pkg::CFG_HYST_LO])
      ttm_pkg::HYST_OFF: hyst_q = ttm_pkg::HYST_Q_OFF;
      ttm_pkg::HYST_1P5: hyst_q = ttm_pkg::HYST_Q_1P5;
      ttm_pkg::HYST_3: hyst_q = ttm_pkg::HYST_Q_3;
      ttm_pkg::HYST_6: hyst_q = ttm_pkg::HYST_Q_6;
    endcase
  end

  // ==========================================================
  // Trip comparators
  assign trip_sel[ttm_pkg::TRIP_UPPER] =
    st_r.upper[ttm_pkg::TRIP_MSB:ttm_pkg::TRIP_LSB];
  assign trip_sel[ttm_pkg::TRIP_LOWER] =
    st_r.lower[ttm_pkg::TRIP_MSB:ttm_pkg::TRIP_LSB];
  assign trip_sel[ttm_pkg::TRIP_CRIT] =
    st_r.crit[ttm_pkg::TRIP_MSB:ttm_pkg::TRIP_LSB];

  for (genvar i = 0; i < ttm_pkg::TRIP_COUNT; i++) begin : g_trip
    ttm_trip u_trip (
      .core_clk(core_clk),
      .rstn(rstn),
      .ce(ce),
      .above_sense(i != ttm_pkg::TRIP_LOWER),
      .temp_q(st_r.temp[ttm_pkg::TEMP_MSB:ttm_pkg::TRIP_LSB]),
      .trip_q(trip_sel[i]),
      .hyst_q(hyst_q),
      .flag(flags[i])
    );
  end

  // ==========================================================
  // Read views
  assign locked_any = st_r.cfg[ttm_pkg::CFG_ALARM_LOCK] |
    st_r.cfg[ttm_pkg::CFG_CRIT_LOCK];

  always_comb begin
    cfg_read = st_r.cfg & ttm_pkg::CFG_STORE_MASK;
    cfg_read[ttm_pkg::CFG_EVT_STAT] = st_r.cfg[ttm_pkg::CFG_EVT_EN] &
      evt_active;
    temp_read = {3'h0, st_r.temp};
    temp_read[ttm_pkg::TEMP_BELOW] = flags[ttm_pkg::TRIP_LOWER];
    temp_read[ttm_pkg::TEMP_ABOVE] = flags[ttm_pkg::TRIP_UPPER];
    temp_read[ttm_pkg::TEMP_CRIT] = flags[ttm_pkg::TRIP_CRIT];
  end

  // ==========================================================
  // Event condition
  always_comb begin
    if (st_r.cfg[ttm_pkg::CFG_CRIT_ONLY]) begin
      evt_cond = flags[ttm_pkg::TRIP_CRIT];
    end else begin
      evt_cond = |flags;
    end
    if (st_r.cfg[ttm_pkg::CFG_EVT_MODE]) begin
      evt_active = st_r.evt_latch;
    end else begin
      evt_active = evt_cond;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;

    // Sensor sampling
    if (sensor_valid && !st_r.cfg[ttm_pkg::CFG_SHUTDOWN]) begin
      st_nxt.temp = sensor_temp;
    end

    // Register writes
    if (wr_en) begin
      unique case (reg_addr)
        ttm_pkg::ADDR_CONFIG: begin
          st_nxt.cfg = wr_data & ttm_pkg::CFG_STORE_MASK;
          if (locked_any) begin
            st_nxt.cfg[ttm_pkg::CFG_EVT_MODE] =
              st_r.cfg[ttm_pkg::CFG_EVT_MODE];
            st_nxt.cfg[ttm_pkg::CFG_EVT_POL] =
              st_r.cfg[ttm_pkg::CFG_EVT_POL];
          end
        end
        ttm_pkg::ADDR_UPPER: begin
          if (!st_r.cfg[ttm_pkg::CFG_ALARM_LOCK]) begin
            st_nxt.upper = wr_data & ttm_pkg::TRIP_MASK;
          end
        end
        ttm_pkg::ADDR_LOWER: begin
          if (!st_r.cfg[ttm_pkg::CFG_ALARM_LOCK]) begin
            st_nxt.lower = wr_data & ttm_pkg::TRIP_MASK;
          end
        end
        ttm_pkg::ADDR_CRITICAL: begin
          if (!st_r.cfg[ttm_pkg::CFG_CRIT_LOCK]) begin
            st_nxt.crit = wr_data & ttm_pkg::TRIP_MASK;
          end
        end
        default: begin
        end
      endcase
    end

    // Interrupt-mode latch: a new event wins over a clear
    st_nxt.cond_prev = evt_cond;
    if (wr_en && reg_addr == ttm_pkg::ADDR_CONFIG &&
        wr_data[ttm_pkg::CFG_CLR_EVT] &&
        st_r.cfg[ttm_pkg::CFG_EVT_MODE]) begin
      st_nxt.evt_latch = 1'b0;
    end
    if (evt_cond && !st_r.cond_prev) begin
      st_nxt.evt_latch = 1'b1;
    end
    if (!st_r.cfg[ttm_pkg::CFG_EVT_MODE]) begin
      st_nxt.evt_latch = 1'b0;
    end

    // Event pin level
    st_nxt.evt_pin = ~st_r.cfg[ttm_pkg::CFG_EVT_POL] ^
      (st_r.cfg[ttm_pkg::CFG_EVT_EN] & evt_active);

    // Register reads
    if (rd_en) begin
      st_nxt.rvalid = 1'b1;
      unique case (reg_addr)
        ttm_pkg::ADDR_CAPABILITY: st_nxt.rdata = CAPABILITY;
        ttm_pkg::ADDR_CONFIG: st_nxt.rdata = cfg_read;
        ttm_pkg::ADDR_UPPER: st_nxt.rdata = st_r.upper;
        ttm_pkg::ADDR_LOWER: st_nxt.rdata = st_r.lower;
        ttm_pkg::ADDR_CRITICAL: st_nxt.rdata = st_r.crit;
        ttm_pkg::ADDR_TEMP: st_nxt.rdata = temp_read;
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r.cfg <= ttm_pkg::CFG_RESET;
      st_r.upper <= ttm_pkg::TRIP_RESET;
      st_r.lower <= ttm_pkg::TRIP_RESET;
      st_r.crit <= ttm_pkg::TRIP_RESET;
      st_r.temp <= ttm_pkg::TEMP_RESET;
      st_r.rdata <= 16'h0000;
      st_r.rvalid <= 1'b0;
      st_r.cond_prev <= 1'b0;
      st_r.evt_latch <= 1'b0;
      st_r.evt_pin <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rdata;
  assign rd_valid = st_r.rvalid;
  assign sensor_shutdown = st_r.cfg[ttm_pkg::CFG_SHUTDOWN];
  assign event_pin = st_r.evt_pin;

  // ==========================================================
  // Checks
  sequence upper_locked_wr_s;
    ce && wr_en && reg_addr == ttm_pkg::ADDR_UPPER &&
      st_r.cfg[ttm_pkg::CFG_ALARM_LOCK];
  endsequence

  sequence upper_open_wr_s;
    ce && wr_en && reg_addr == ttm_pkg::ADDR_UPPER &&
      !st_r.cfg[ttm_pkg::CFG_ALARM_LOCK];
  endsequence

  sequence crit_locked_wr_s;
    ce && wr_en && reg_addr == ttm_pkg::ADDR_CRITICAL &&
      st_r.cfg[ttm_pkg::CFG_CRIT_LOCK];
  endsequence

  sequence lower_locked_wr_s;
    ce && wr_en && reg_addr == ttm_pkg::ADDR_LOWER &&
      st_r.cfg[ttm_pkg::CFG_ALARM_LOCK];
  endsequence

  sequence crit_open_wr_s;
    ce && wr_en && reg_addr == ttm_pkg::ADDR_CRITICAL &&
      !st_r.cfg[ttm_pkg::CFG_CRIT_LOCK];
  endsequence

  sequence evt_rise_s;
    ce && st_r.cfg[ttm_pkg::CFG_EVT_MODE] && evt_cond && !st_r.cond_prev;
  endsequence

  sequence evt_clear_s;
    ce && wr_en && reg_addr == ttm_pkg::ADDR_CONFIG &&
      wr_data[ttm_pkg::CFG_CLR_EVT] && st_r.cfg[ttm_pkg::CFG_EVT_MODE];
  endsequence

  upper_lock_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    upper_locked_wr_s |=> $stable(st_r.upper))
    else $error("locked upper bound changed");

  lower_lock_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    lower_locked_wr_s |=> $stable(st_r.lower))
    else $error("locked lower bound changed");

  upper_write_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    upper_open_wr_s |=> st_r.upper == ($past(wr_data) & ttm_pkg::TRIP_MASK))
    else $error("open upper bound write not stored");

  crit_lock_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    crit_locked_wr_s |=> $stable(st_r.crit))
    else $error("locked critical limit changed");

  crit_write_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    crit_open_wr_s |=> st_r.crit == ($past(wr_data) & ttm_pkg::TRIP_MASK))
    else $error("open critical limit write not stored");

  shutdown_hold_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    ce && st_r.cfg[ttm_pkg::CFG_SHUTDOWN] |=> $stable(st_r.temp))
    else $error("temperature moved in shutdown");

  temp_take_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    ce && sensor_valid && !st_r.cfg[ttm_pkg::CFG_SHUTDOWN] |=>
      st_r.temp == $past(sensor_temp))
    else $error("sensor sample not taken while running");

  latch_set_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    evt_rise_s |=> st_r.evt_latch)
    else $error("event latch missed a new event");

  latch_clear_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    evt_clear_s ##0 !(evt_cond && !st_r.cond_prev) |=>
      !st_r.evt_latch)
    else $error("event latch not cleared by clear request");

  pin_drive_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    ce && st_r.cfg[ttm_pkg::CFG_EVT_EN] && evt_active |=>
      event_pin == $past(st_r.cfg[ttm_pkg::CFG_EVT_POL]))
    else $error("event pin not at active level");

  pin_idle_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    ce && !st_r.cfg[ttm_pkg::CFG_EVT_EN] |=>
      event_pin == !$past(st_r.cfg[ttm_pkg::CFG_EVT_POL]))
    else $error("disabled event pin not idle");

  mode_lock_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    ce && wr_en && reg_addr == ttm_pkg::ADDR_CONFIG && locked_any |=>
      $stable(st_r.cfg[ttm_pkg::CFG_EVT_POL:ttm_pkg::CFG_EVT_MODE]))
    else $error("event mode or polarity changed under lock");

  temp_read_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    ce && rd_en && reg_addr == ttm_pkg::ADDR_TEMP |=>
      rd_valid && rd_data == {$past(flags[ttm_pkg::TRIP_CRIT]),
      $past(flags[ttm_pkg::TRIP_UPPER]), $past(flags[ttm_pkg::TRIP_LOWER]),
      $past(st_r.temp)})
    else $error("temperature readout mismatch");

  trip_zero_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    ce && rd_en && reg_addr >= ttm_pkg::ADDR_UPPER &&
      reg_addr <= ttm_pkg::ADDR_CRITICAL |=>
      rd_data[15:13] == 3'h0 && rd_data[1:0] == 2'h0)
    else $error("reserved trip bits not zero");

  hyst_six_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    st_r.cfg[ttm_pkg::CFG_HYST_HI:ttm_pkg::CFG_HYST_LO] == ttm_pkg::HYST_6
      |-> hyst_q == ttm_pkg::HYST_Q_6)
    else $error("hysteresis decode wrong");

endmodule

//--- dv/ttm_sensor_model.sv
// Behavioural sensor that feeds samples to the monitor's sensor port.
// Assumes the bench sets the temperature and drives on core_clk falls.
`timescale 1ns/1ps
module ttm_sensor_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bench control
  input wire logic [12:0] temp_in,
  input wire logic keep_sampling,
  // Device sample port
  input wire logic sensor_shutdown,
  output logic sensor_valid,
  output logic [12:0] sensor_temp
);
  // ==========================================================
  // Sample stream, stopped while the device is shut down unless keep_sampling is set
  always @(negedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sensor_valid <= 1'b0;
      sensor_temp <= 13'h0000;
    end else if (sensor_shutdown && !keep_sampling) begin
      sensor_valid <= 1'b0;
      sensor_temp <= ~sensor_temp;
    end else begin
      sensor_valid <= 1'b1;
      sensor_temp <= temp_in;
    end
  end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the thermal trip monitor.
// Assumes ttm_pkg, ttm_monitor and the sensor model are compiled first.
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Signals
  logic core_clk, rstn, wr_en, rd_en, keep_sampling, ce;
  logic sensor_valid, sensor_shutdown, event_pin, rd_valid;
  logic [2:0] reg_addr;
  logic [15:0] wr_data, rd_data, rv;
  logic [12:0] sensor_temp, temp_in, hq;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  ttm_monitor uut (.core_clk(core_clk), .rstn(rstn), .ce(ce),
    .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .sensor_valid(sensor_valid), .sensor_temp(sensor_temp),
    .sensor_shutdown(sensor_shutdown), .event_pin(event_pin));

  ttm_sensor_model sensor (.core_clk(core_clk), .rstn(rstn),
    .temp_in(temp_in), .keep_sampling(keep_sampling),
    .sensor_shutdown(sensor_shutdown), .sensor_valid(sensor_valid),
    .sensor_temp(sensor_temp));

  // ==========================================================
  // Clock and timeout
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("ERROR timeout expected finish seen hang");
      print_verdict();
    end
  end

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("Checks run %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge core_clk);
    wr_en = 1'b1;
    reg_addr = a;
    wr_data = d;
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    int n;
    @(negedge core_clk);
    rd_en = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    rd_en = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 4) begin
      failures++;
      $display("ERROR rd_valid expected 1 seen 0");
    end
    d = rd_data;
  endtask

  task automatic rchk(input string name, input logic [2:0] a,
                      input logic [15:0] exp);
    rd(a, rv);
    check(name, rv, exp);
  endtask

  // Flags order: critical, above, below
  task automatic step(input logic [12:0] t, input logic [2:0] f);
    temp_in = t;
    repeat (5) @(negedge core_clk);
    rchk("temperature", ttm_pkg::ADDR_TEMP, {f, t});
    check("event_pin", {15'h0000, event_pin}, {15'h0000, |f});
  endtask

  // Event pin level after a temperature settles
  task automatic pin(input logic [12:0] t, input logic e);
    temp_in = t;
    repeat (6) @(negedge core_clk);
    check("event_pin", {15'h0000, event_pin}, {15'h0000, e});
  endtask

  // ==========================================================
  // Tests
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    reg_addr = 3'h0;
    wr_data = 16'h0000;
    temp_in = 13'h0000;
    keep_sampling = 1'b0;
    hq = 13'h0000;
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    rchk("config", ttm_pkg::ADDR_CONFIG, 16'h0000);
    for (int a = 2; a < 6; a++) begin
      rchk("reset value", a[2:0], 16'h0000);
    end
    rchk("unmapped", 3'h6, 16'h0000);
    $display("test reset_values done");
    for (int a = 2; a < 5; a++) begin
      wr(a[2:0], 16'hFFFF);
      rchk("trip field", a[2:0], 16'h1FFC);
    end
    $display("test trip_masking done");
    wr(ttm_pkg::ADDR_CONFIG, 16'h0040);
    wr(ttm_pkg::ADDR_CONFIG, 16'h0043);
    rchk("config", ttm_pkg::ADDR_CONFIG, 16'h0040);
    wr(ttm_pkg::ADDR_UPPER, 16'h0100);
    rchk("upper", ttm_pkg::ADDR_UPPER, 16'h1FFC);
    wr(ttm_pkg::ADDR_LOWER, 16'h0100);
    rchk("lower", ttm_pkg::ADDR_LOWER, 16'h1FFC);
    wr(ttm_pkg::ADDR_CRITICAL, 16'h03C0);
    rchk("critical", ttm_pkg::ADDR_CRITICAL, 16'h03C0);
    wr(ttm_pkg::ADDR_CONFIG, 16'h0080);
    wr(ttm_pkg::ADDR_CONFIG, 16'h0083);
    rchk("config", ttm_pkg::ADDR_CONFIG, 16'h0080);
    wr(ttm_pkg::ADDR_UPPER, 16'h0280);
    rchk("upper", ttm_pkg::ADDR_UPPER, 16'h0280);
    wr(ttm_pkg::ADDR_LOWER, 16'h0140);
    rchk("lower", ttm_pkg::ADDR_LOWER, 16'h0140);
    wr(ttm_pkg::ADDR_CRITICAL, 16'h0111);
    rchk("critical", ttm_pkg::ADDR_CRITICAL, 16'h03C0);
    wr(ttm_pkg::ADDR_CONFIG, 16'h0000);
    rchk("config", ttm_pkg::ADDR_CONFIG, 16'h0000);
    $display("test lock_bits done");
    wr(ttm_pkg::ADDR_CONFIG, 16'h000A);
    wr(ttm_pkg::ADDR_TEMP, 16'hFFFF);
    step(13'h0200, 3'b000);
    $display("test temperature_read_only done");
    for (int h = 0; h < 4; h++) begin
      hq = (h == 0) ? 13'h0000 : (13'h0018 << (h - 1));
      wr(ttm_pkg::ADDR_CONFIG, {5'h00, h[1:0], 9'h00A});
      rchk("config", ttm_pkg::ADDR_CONFIG, {5'h00, h[1:0], 9'h00A});
      step(13'h0280, 3'b000);
      step(13'h0284, 3'b010);
      step(13'h0284 - hq, 3'b010);
      step(13'h0280 - hq, 3'b000);
      step(13'h0140 - hq, 3'b000);
      step(13'h013C - hq, 3'b001);
      step(13'h013C, 3'b001);
      step(13'h0140, 3'b000);
      step(13'h03C4, 3'b110);
      step(13'h03C4 - hq, 3'b110);
      step(13'h03C0 - hq, 3'b010);
      step(13'h0200, 3'b000);
    end
    $display("test hysteresis done");
    wr(ttm_pkg::ADDR_CONFIG, 16'h000A);
    wr(ttm_pkg::ADDR_LOWER, 16'h1E74);
    rchk("lower", ttm_pkg::ADDR_LOWER, 16'h1E74);
    step(13'h1E70, 3'b001);
    $display("test negative_values done");
    wr(ttm_pkg::ADDR_CONFIG, 16'h010A);
    check("sensor_shutdown", {15'h0000, sensor_shutdown}, 16'h0001);
    keep_sampling = 1'b1;
    temp_in = 13'h0300;
    repeat (5) @(negedge core_clk);
    rchk("temperature", ttm_pkg::ADDR_TEMP, 16'h3E70);
    keep_sampling = 1'b0;
    wr(ttm_pkg::ADDR_CONFIG, 16'h000A);
    step(13'h0300, 3'b010);
    $display("test shutdown done");
    rchk("config", ttm_pkg::ADDR_CONFIG, 16'h001A);
    wr(ttm_pkg::ADDR_CONFIG, 16'h0008);
    pin(13'h0300, 1'b0);
    wr(ttm_pkg::ADDR_CONFIG, 16'h000C);
    pin(13'h0300, 1'b1);
    wr(ttm_pkg::ADDR_CONFIG, 16'h0009);
    pin(13'h0300, 1'b0);
    wr(ttm_pkg::ADDR_CONFIG, 16'h0029);
    pin(13'h0300, 1'b1);
    rchk("config", ttm_pkg::ADDR_CONFIG, 16'h0009);
    pin(13'h0200, 1'b1);
    pin(13'h0300, 1'b0);
    pin(13'h0200, 1'b0);
    wr(ttm_pkg::ADDR_CONFIG, 16'h0029);
    pin(13'h0200, 1'b1);
    $display("test event_modes done");
    ce = 1'b0;
    wr(ttm_pkg::ADDR_UPPER, 16'h0300);
    ce = 1'b1;
    rchk("upper", ttm_pkg::ADDR_UPPER, 16'h0280);
    $display("test clock_enable done");
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    check("event_pin", {15'h0000, event_pin}, 16'h0001);
    rchk("upper", ttm_pkg::ADDR_UPPER, 16'h0000);
    rchk("config", ttm_pkg::ADDR_CONFIG, 16'h0000);
    $display("test mid_reset done");
    print_verdict();
  end
endmodule
